/* rtl/block_write_defines.vh */
`ifndef BLOCK_WRITE_DEFINES_VH
`define BLOCK_WRITE_DEFINES_VH
// local ram layout
`define TABLE_AREA_BYTES   12'h200
`define LOCAL_RAM_BYTES    12'he00
`define TABLE_BYTES_PER_CH 12'h020
// channel control opcodes
`define CMD_START_IO       3'h1
`define CMD_STOP_IO        3'h2
`define CMD_BLOCK_WRITE    3'h3
`define CMD_BLOCK_READ     3'h4
// control word format carrying the block mode select
`define CTRL_FORMAT_BLOCK  2'h2
// status byte values written back into the control block
`define STATUS_OK          8'h80
`define STATUS_BAD_ADDR    8'hc0
`endif

/* rtl/pair_buffer.v */
`timescale 1ns/1ps
`include "block_write_defines.vh"
module pair_buffer #(
   parameter WIDTH = 8
) (
   input  wire             core_clk,
   input  wire             nrst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] slot_reg [0:1];
   reg             rd_ptr_reg;
   reg             wr_ptr_reg;
   reg [1:0]       count_reg;
   wire            push;
   wire            pop;

   assign in_ready  = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data  = slot_reg[rd_ptr_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // two-slot ring with count
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
         slot_reg[0] <= {WIDTH{1'b0}};
         slot_reg[1] <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            slot_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

/* rtl/block_write_engine.v */
`timescale 1ns/1ps
`include "block_write_defines.vh"
// Behaviour
// - one control block, channel idle meanwhile
// - completion returns channel to stopped
// - interrupt at assigned level, none if unset
// - no initialisation, other channels keep running
// - any stopped adapter-equipped transmit channel with a loaded block accepted
// - destination anywhere in table or program area
// - table 512 bytes, total 3584 bytes
// - block read over receive channel supported
// - ram address increments per byte written
// - status and final ram address written to bytes zero and one at the loaded memory address
module block_write_engine #(
   parameter CH_BITS   = 4,
   parameter MEM_AW    = 24,
   parameter LEVEL_W   = 6
) (
   input  wire                  core_clk,
   input  wire                  nrst,
   // host instruction port
   input  wire                  cmd_valid,
   input  wire [2:0]            cmd_op,
   input  wire [CH_BITS-1:0]    cmd_chan,
   input  wire                  cmd_is_tx,
   input  wire [MEM_AW-1:0]     cmd_mem_addr,
   input  wire [15:0]           cmd_range,
   input  wire                  cmd_addr_load,
   input  wire                  cmd_ctrl_load,
   input  wire [1:0]            cmd_ctrl_format,
   input  wire [11:0]           cmd_ram_addr,
   input  wire [(1<<CH_BITS)-1:0] adapter_present,
   input  wire [(1<<CH_BITS)-1:0] chan_stopped,
   input  wire [(1<<CH_BITS)*LEVEL_W-1:0] chan_level,
   output reg                   cmd_ack,
   output reg                   cmd_reject,
   // main memory read port
   output reg                   mem_req,
   output reg  [MEM_AW-1:0]     mem_addr,
   input  wire                  mem_gnt,
   input  wire                  mem_rvalid,
   input  wire [7:0]            mem_rdata,
   // main memory write port for block read and status
   output reg                   mem_wr,
   output reg  [MEM_AW-1:0]     mem_wr_addr,
   output reg  [7:0]            mem_wdata,
   input  wire                  mem_wr_ack,
   // local ram port
   output reg                   ram_we,
   output reg                   ram_re,
   output reg  [11:0]           ram_addr,
   output reg  [7:0]            ram_wdata,
   input  wire [7:0]            ram_rdata,
   // channel control
   output reg                   busy,
   output reg  [CH_BITS-1:0]    busy_chan,
   output reg                   stop_pulse,
   output reg  [CH_BITS-1:0]    stop_chan,
   output reg                   irq_pulse,
   output reg  [LEVEL_W-1:0]    irq_level
);
   localparam S_IDLE  = 3'h0;
   localparam S_FETCH = 3'h1;
   localparam S_WAIT  = 3'h2;
   localparam S_RDRAM = 3'h3;
   localparam S_PUSH  = 3'h4;
   localparam S_DRAIN = 3'h5;
   localparam S_STAT6 = 3'h6;
   localparam S_STAT7 = 3'h7;

   reg [2:0]          state_reg;
   reg                is_read_reg;
   reg [MEM_AW-1:0]   ccb_mem_reg;
   reg [15:0]         ccb_range_reg;
   reg [11:0]         ccb_ram_reg;
   reg                ccb_ready_reg;
   reg [CH_BITS-1:0]  ccb_chan_reg;
   reg [MEM_AW-1:0]   ccb_base_reg;
   reg [15:0]         issued_reg;
   reg [7:0]          status_reg;
   wire               buf_in_ready;
   wire [7:0]         buf_out_data;
   wire               buf_out_valid;
   wire               buf_out_ready;
   wire               buf_in_valid;
   wire [7:0]         buf_in_data;
   wire               start_ok;
   wire               addr_ok;

   // destination bound, any byte of table or program area
   assign addr_ok = (cmd_ram_addr < `LOCAL_RAM_BYTES);
   // start accepted on any stopped adapter-equipped channel with a loaded block
   assign start_ok = adapter_present[cmd_chan] & chan_stopped[cmd_chan]
                   & ccb_ready_reg & (ccb_chan_reg == cmd_chan);

   // data words pass through the two-entry buffer
   assign buf_in_valid  = is_read_reg ? (state_reg == S_PUSH) : mem_rvalid; // ram data one cycle late
   assign buf_in_data   = is_read_reg ? ram_rdata : mem_rdata;
   assign buf_out_ready = is_read_reg ? ~mem_wr | mem_wr_ack : 1'b1;

   pair_buffer #(.WIDTH(8)) u_buf (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .in_data   (buf_in_data),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .out_data  (buf_out_data),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready)
   );

   // main control sequence
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg     <= S_IDLE;
         is_read_reg   <= 1'b0;
         ccb_mem_reg   <= {MEM_AW{1'b0}};
         ccb_base_reg  <= {MEM_AW{1'b0}};
         ccb_range_reg <= 16'h0000;
         ccb_ram_reg   <= 12'h000;
         ccb_ready_reg <= 1'b0;
         ccb_chan_reg  <= {CH_BITS{1'b0}};
         issued_reg    <= 16'h0000;
         status_reg    <= 8'h00;
         cmd_ack       <= 1'b0;
         cmd_reject    <= 1'b0;
         mem_req       <= 1'b0;
         mem_addr      <= {MEM_AW{1'b0}};
         mem_wr        <= 1'b0;
         mem_wr_addr   <= {MEM_AW{1'b0}};
         mem_wdata     <= 8'h00;
         ram_we        <= 1'b0;
         ram_re        <= 1'b0;
         ram_addr      <= 12'h000;
         ram_wdata     <= 8'h00;
         busy          <= 1'b0;
         busy_chan     <= {CH_BITS{1'b0}};
         stop_pulse    <= 1'b0;
         stop_chan     <= {CH_BITS{1'b0}};
         irq_pulse     <= 1'b0;
         irq_level     <= {LEVEL_W{1'b0}};
      end else begin
         cmd_ack    <= 1'b0;
         cmd_reject <= 1'b0;
         ram_we     <= 1'b0;
         ram_re     <= 1'b0;
         stop_pulse <= 1'b0;
         irq_pulse  <= 1'b0;
         if (mem_wr & mem_wr_ack)
            mem_wr <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (cmd_valid) begin
                  cmd_ack <= 1'b1;
                  if (cmd_addr_load) begin
                     ccb_mem_reg   <= cmd_mem_addr;
                     ccb_base_reg  <= cmd_mem_addr;
                     ccb_range_reg <= cmd_range;
                     ccb_chan_reg  <= cmd_chan;
                     ccb_ready_reg <= 1'b0;
                  end else if (cmd_ctrl_load) begin
                     ccb_ram_reg   <= cmd_ram_addr;
                     ccb_ready_reg <= (cmd_ctrl_format == `CTRL_FORMAT_BLOCK) & addr_ok;
                  end else if (cmd_op == `CMD_BLOCK_WRITE && cmd_is_tx && start_ok) begin
                     // one control block used, channel idle
                     ccb_ready_reg <= 1'b0;
                     is_read_reg   <= 1'b0;
                     busy          <= 1'b1;
                     busy_chan     <= cmd_chan;
                     issued_reg    <= 16'h0000;
                     status_reg    <= `STATUS_OK;
                     state_reg     <= S_FETCH;
                  end else if (cmd_op == `CMD_BLOCK_READ && !cmd_is_tx && start_ok) begin
                     ccb_ready_reg <= 1'b0;
                     is_read_reg   <= 1'b1;
                     busy          <= 1'b1;
                     busy_chan     <= cmd_chan;
                     status_reg    <= `STATUS_OK;
                     state_reg     <= S_RDRAM;
                  end else if (cmd_op == `CMD_BLOCK_WRITE || cmd_op == `CMD_BLOCK_READ) begin
                     cmd_ack    <= 1'b0;
                     cmd_reject <= 1'b1;
                  end
               end
            end
            S_FETCH: begin
               // request source bytes while range remains
               if (issued_reg == ccb_range_reg) begin
                  state_reg <= S_DRAIN;
               end else if (buf_in_ready) begin
                  mem_req   <= 1'b1;
                  mem_addr  <= ccb_mem_reg;
                  state_reg <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (mem_gnt) begin
                  mem_req     <= 1'b0;
                  ccb_mem_reg <= ccb_mem_reg + {{(MEM_AW-1){1'b0}}, 1'b1};
                  issued_reg  <= issued_reg + 16'h0001;
                  state_reg   <= S_FETCH;
               end
            end
            S_RDRAM: begin
               // block read: local ram to main memory
               if (ccb_range_reg == 16'h0000) begin
                  state_reg <= S_DRAIN;
               end else if (buf_in_ready) begin
                  ram_re        <= 1'b1;
                  ram_addr      <= ccb_ram_reg;
                  ccb_ram_reg   <= ccb_ram_reg + 12'h001;
                  ccb_range_reg <= ccb_range_reg - 16'h0001;
                  state_reg     <= S_PUSH;
               end
            end
            S_PUSH: begin
               state_reg <= S_RDRAM;
            end
            S_DRAIN: begin
               if (!buf_out_valid && !mem_wr && !mem_req) begin
                  mem_wr      <= 1'b1;
                  mem_wr_addr <= ccb_base_reg;
                  mem_wdata   <= status_reg;
                  state_reg   <= S_STAT6;
               end
            end
            S_STAT6: begin
               if (mem_wr_ack) begin
                  mem_wr      <= 1'b1;
                  mem_wr_addr <= ccb_base_reg + {{(MEM_AW-1){1'b0}}, 1'b1};
                  mem_wdata   <= ccb_ram_reg[7:0];
                  state_reg   <= S_STAT7;
               end
            end
            S_STAT7: begin
               if (mem_wr & mem_wr_ack) begin
                  // back to stopped, interrupt only when level set
                  busy       <= 1'b0;
                  stop_pulse <= 1'b1;
                  stop_chan  <= busy_chan;
                  irq_level  <= chan_level[busy_chan*LEVEL_W +: LEVEL_W];
                  irq_pulse  <= |chan_level[busy_chan*LEVEL_W +: LEVEL_W];
                  state_reg  <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
         // write side: buffer output to local ram, address steps per byte
         if (!is_read_reg && buf_out_valid && busy) begin
            ccb_ram_reg <= ccb_ram_reg + 12'h001;
            if (ccb_ram_reg < `LOCAL_RAM_BYTES) begin
               ram_we    <= 1'b1;
               ram_addr  <= ccb_ram_reg;
               ram_wdata <= buf_out_data;
            end else begin
               // past the program area: byte dropped, flagged in status
               status_reg <= `STATUS_BAD_ADDR;
            end
         end
         // read side: buffer output to main memory
         if (is_read_reg && buf_out_valid && buf_out_ready && busy) begin
            mem_wr      <= 1'b1;
            mem_wr_addr <= ccb_mem_reg;
            mem_wdata   <= buf_out_data;
            ccb_mem_reg <= ccb_mem_reg + {{(MEM_AW-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

/* dv/bw_checker_sva.sv */
`timescale 1ns/1ps
`include "block_write_defines.vh"
module bw_checker #(
   parameter CH_BITS = 4,
   parameter MEM_AW  = 24,
   parameter LEVEL_W = 6
) (
   input wire               core_clk,
   input wire               nrst,
   input wire               cmd_valid,
   input wire [2:0]         cmd_op,
   input wire               cmd_addr_load,
   input wire               cmd_ctrl_load,
   input wire               cmd_ack,
   input wire               cmd_reject,
   input wire               mem_req,
   input wire [MEM_AW-1:0]  mem_addr,
   input wire               mem_gnt,
   input wire               mem_wr,
   input wire [7:0]         mem_wdata,
   input wire               mem_wr_ack,
   input wire               ram_we,
   input wire [11:0]        ram_addr,
   input wire               busy,
   input wire [CH_BITS-1:0] busy_chan,
   input wire               stop_pulse,
   input wire [CH_BITS-1:0] stop_chan,
   input wire               irq_pulse,
   input wire [LEVEL_W-1:0] irq_level
);
   reg [11:0] last_reg;
   reg        seen_reg;
   // previous ram write address of the running transfer
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         last_reg <= 12'h000;
         seen_reg <= 1'b0;
      end else if (ram_we) begin
         last_reg <= ram_addr;
         seen_reg <= 1'b1;
      end else if (!busy) begin
         seen_reg <= 1'b0;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // start request seen while idle
   sequence s_start;
      cmd_valid && !busy && !cmd_addr_load && !cmd_ctrl_load && cmd_op == `CMD_BLOCK_WRITE;
   endsequence
   sequence s_accept;
      s_start ##1 cmd_ack;
   endsequence
   AST_START_ANSWER: assert property (s_start |=> cmd_ack ^ cmd_reject)
      else $error("start got no single answer");
   AST_BUSY_ON_ACK: assert property (s_accept |-> busy)
      else $error("accepted start without busy");
   AST_RAM_STEP: assert property (ram_we && seen_reg |-> ram_addr == last_reg + 12'h001)
      else $error("ram address did not step by one");
   AST_RAM_LIMIT: assert property (ram_we |-> ram_addr < 12'he00)
      else $error("ram write beyond local ram");
   AST_IDLE_NO_WRITE: assert property (!busy |-> !ram_we)
      else $error("ram write while idle");
   AST_REQ_HOLD: assert property (mem_req && !mem_gnt |=> mem_req && $stable(mem_addr))
      else $error("memory request dropped before grant");
   AST_WR_HOLD: assert property (mem_wr && !mem_wr_ack |=> mem_wr && $stable(mem_wdata))
      else $error("status write dropped before ack");
   AST_STOP_CHAN: assert property (stop_pulse |-> stop_chan == $past(busy_chan))
      else $error("stop on wrong channel");
   AST_IRQ_LEVEL: assert property (irq_pulse |-> irq_level != 0 && stop_pulse)
      else $error("interrupt without level or stop");
endmodule
bind block_write_engine bw_checker #(.CH_BITS(CH_BITS), .MEM_AW(MEM_AW), .LEVEL_W(LEVEL_W))
   bw_checker_i (
   .core_clk      (core_clk),
   .nrst          (nrst),
   .cmd_valid     (cmd_valid),
   .cmd_op        (cmd_op),
   .cmd_addr_load (cmd_addr_load),
   .cmd_ctrl_load (cmd_ctrl_load),
   .cmd_ack       (cmd_ack),
   .cmd_reject    (cmd_reject),
   .mem_req       (mem_req),
   .mem_addr      (mem_addr),
   .mem_gnt       (mem_gnt),
   .mem_wr        (mem_wr),
   .mem_wdata     (mem_wdata),
   .mem_wr_ack    (mem_wr_ack),
   .ram_we        (ram_we),
   .ram_addr      (ram_addr),
   .busy          (busy),
   .busy_chan     (busy_chan),
   .stop_pulse    (stop_pulse),
   .stop_chan     (stop_chan),
   .irq_pulse     (irq_pulse),
   .irq_level     (irq_level)
);

/* dv/mem_model.sv */
`timescale 1ns/1ps
module mem_model #(
   parameter MEM_AW = 24
) (
   input wire              core_clk,
   input wire              nrst,
   input wire              slow,
   input wire              mem_req,
   input wire [MEM_AW-1:0] mem_addr,
   output reg              mem_gnt,
   output reg              mem_rvalid,
   output reg [7:0]        mem_rdata,
   input wire              mem_wr,
   output reg              mem_wr_ack
);
   // one-cycle grant and ack, randomly late when slow; data lines toggle when idle
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mem_gnt <= 1'b0;
         mem_rvalid <= 1'b0;
         mem_rdata <= 8'h00;
         mem_wr_ack <= 1'b0;
      end else begin
         mem_gnt <= mem_req && !mem_gnt && (!slow || $urandom_range(1) == 1);
         mem_wr_ack <= mem_wr && !mem_wr_ack && (!slow || $urandom_range(1) == 1);
         mem_rvalid <= mem_req && mem_gnt;
         mem_rdata <= (mem_req && mem_gnt) ? (mem_addr[7:0] ^ 8'h5a) : ~mem_rdata;
      end
   end
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
`include "block_write_defines.vh"
module tb_top;
   logic        core_clk, nrst, cmd_valid, cmd_is_tx, cmd_addr_load, cmd_ctrl_load, slow, rd;
   logic        cmd_ack, cmd_reject, mem_req, mem_gnt, mem_rvalid, mem_wr, mem_wr_ack;
   logic        ram_we, ram_re, busy, stop_pulse, irq_pulse;
   logic [2:0]  cmd_op;
   logic [1:0]  cmd_ctrl_format;
   logic [3:0]  cmd_chan, busy_chan, stop_chan;
   logic [5:0]  irq_level;
   logic [7:0]  mem_rdata, mem_wdata, ram_wdata;
   logic [11:0] cmd_ram_addr, ram_addr;
   logic [15:0] cmd_range, adapter_present, chan_stopped;
   logic [23:0] cmd_mem_addr, mem_addr, mem_wr_addr;
   logic [95:0] chan_level;
   wire  [7:0]  ram_rdata = ~ram_addr[7:0];
   integer      errors, comparisons, i, rng;
   block_write_engine block_write_engine_i (.*);
   mem_model mem_model_i (.*);
   // free running core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task chk(input bit bad, input string msg);
      comparisons = comparisons + 1;
      if (bad) begin
         errors = errors + 1;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task conclude;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one command strobe, then a bounded wait for its answer
   task cmd(input bit al, input bit cl, input [2:0] op, output bit rej);
      integer n;
      cmd_addr_load = al;
      cmd_ctrl_load = cl;
      cmd_op = op;
      cmd_valid = 1'b1;
      @(posedge core_clk);
      #1 cmd_valid = 1'b0;
      for (n = 0; n < 10 && cmd_ack !== 1'b1 && cmd_reject !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      chk(n == 10, "no answer");
      if (n == 10) conclude;
      rej = (cmd_reject === 1'b1);
      @(posedge core_clk);
      #1;
   endtask
   // full host sequence and monitor of the transfer
   task run(input [3:0] ch, input [11:0] ra, input [15:0] rn, input [5:0] lv,
            input bit stp, input bit adp, input bit xrej);
      integer n, k, nw, nd;
      bit r, st, iq;
      logic [7:0] w [2];
      nd = rd ? rn : 0;
      chan_stopped = 16'($urandom);
      chan_stopped[ch] = stp;
      adapter_present = 16'($urandom);
      adapter_present[ch] = adp;
      chan_level = {$urandom, $urandom, $urandom};
      chan_level[ch*6 +: 6] = lv;
      cmd_chan = ch;
      cmd_is_tx = !rd;
      cmd_mem_addr = 24'($urandom);
      cmd_range = rn;
      cmd_ram_addr = ra;
      cmd_ctrl_format = `CTRL_FORMAT_BLOCK;
      cmd(1'b1, 1'b0, 3'h0, r);
      cmd(1'b0, 1'b1, 3'h0, r);
      cmd(1'b0, 1'b0, rd ? `CMD_BLOCK_READ : `CMD_BLOCK_WRITE, r);
      chk(r !== xrej, "start answer");
      if (!xrej) begin
         k = 0;
         nw = 0;
         st = 0;
         iq = 0;
         for (n = 0; n < 600 && !(st && busy === 1'b0); n++) begin
            if (busy === 1'b1) chk(busy_chan !== ch, "busy channel");
            if ((rd ? ram_re : ram_we) === 1'b1) begin
               chk(ram_addr !== ra + k[11:0], "ram address");
               if (!rd)
                  chk(ram_wdata !== ((cmd_mem_addr[7:0] + k[7:0]) ^ 8'h5a), "ram data");
               k = k + 1;
            end
            if (rd) chk(ram_we === 1'b1, "ram write in read");
            if (mem_wr === 1'b1 && mem_wr_ack === 1'b1) begin
               if (nw < nd) begin
                  chk(mem_wr_addr !== cmd_mem_addr + nw[23:0], "read address");
                  chk(mem_wdata !== ~(ra[7:0] + nw[7:0]), "read data");
               end else if (nw < nd + 2) begin
                  w[nw - nd] = mem_wdata;
               end
               nw = nw + 1;
            end
            if (stop_pulse === 1'b1) begin
               st = 1;
               chk(stop_chan !== ch, "stop channel");
            end
            if (irq_pulse === 1'b1) begin
               iq = 1;
               chk(irq_level !== lv, "irq level");
            end
            @(posedge core_clk);
            #1;
         end
         chk(n == 600, "transfer hang");
         if (n == 600) conclude;
         chk(k != rn, "byte count");
         chk(iq != (lv != 0), "irq presence");
         chk(nw != nd + 2 || w[0] !== `STATUS_OK, "status byte");
         chk(w[1] !== ra[7:0] + rn[7:0], "final ram address");
      end
   endtask
   // reset, corner cases, then random transfers
   initial begin
      errors = 0;
      comparisons = 0;
      {nrst, cmd_valid, cmd_is_tx, cmd_addr_load, cmd_ctrl_load, slow, rd, cmd_op} = 0;
      {cmd_ctrl_format, cmd_chan, cmd_ram_addr, cmd_range, cmd_mem_addr} = 0;
      {adapter_present, chan_stopped, chan_level} = 0;
      void'($urandom(77));
      repeat (4) @(posedge core_clk);
      #1 nrst = 1'b1;
      run(4'h1, 12'h000, 16'd1, 6'h05, 1, 1, 0);
      run(4'hf, 12'hdfc, 16'd4, 6'h00, 1, 1, 0);
      run(4'h3, 12'h1fe, 16'd5, 6'h3f, 1, 1, 0);
      run(4'h2, 12'h210, 16'd3, 6'h01, 0, 1, 1);
      run(4'h2, 12'h210, 16'd3, 6'h01, 1, 0, 1);
      run(4'h2, 12'he00, 16'd1, 6'h01, 1, 1, 1);
      rd = 1'b1;
      run(4'h6, 12'h3f0, 16'd6, 6'h02, 1, 1, 0);
      // program area destinations keep clear of every table
      for (i = 0; i < 8; i++) begin
         slow = i[0];
         rd = i[1];
         rng = 1 + $urandom_range(7);
         run(4'($urandom), 12'h200 + 12'($urandom_range(3000)), 16'(rng), 6'($urandom),
             1, 1, 0);
      end
      conclude;
   end
endmodule
